// [common/plcc_defs.svh]
// register offsets, field positions and reset values of the link capability / control bank
`ifndef PLCC_DEFS_SVH
`define PLCC_DEFS_SVH

`define PLCC_ADDR_W        8
`define PLCC_OFF_LINK_CAP  8'hcc
`define PLCC_OFF_LINK_CTL  8'hd0
`define PLCC_OFF_LOAD_PORT 8'he0
`define PLCC_NUM_PORTS     4
`define PLCC_PORT_W        2

// capability fields
`define PLCC_CAP_SPEED_LO  0
`define PLCC_CAP_SPEED_HI  3
`define PLCC_CAP_WIDTH_LO  4
`define PLCC_CAP_WIDTH_HI  9
`define PLCC_CAP_ASPM_LO   10
`define PLCC_CAP_ASPM_HI   11
`define PLCC_CAP_L0S_LO    12
`define PLCC_CAP_L0S_HI    14
`define PLCC_CAP_L1_LO     15
`define PLCC_CAP_L1_HI     17
`define PLCC_CAP_DLLA      20
`define PLCC_CAP_BWN       21
`define PLCC_CAP_PNUM_LO   24
`define PLCC_CAP_PNUM_HI   31

`define PLCC_RST_SPEED     4'h2
`define PLCC_RST_WIDTH     6'h01
`define PLCC_RST_ASPM      2'h0
`define PLCC_RST_L0S       3'h3
`define PLCC_RST_L1        3'h0

// control fields
`define PLCC_CTL_ASPM_LO   0
`define PLCC_CTL_ASPM_HI   1
`define PLCC_CTL_RCB       3
`define PLCC_CTL_DISABLE   4
`define PLCC_CTL_RETRAIN   5
`define PLCC_CTL_CCLK      6
`define PLCC_CTL_EXTSYNC   7
`define PLCC_CTL_HAWD      9
`define PLCC_CTL_BWMIE     10
`define PLCC_CTL_ABWIE     11

`define PLCC_ASPM_OFF      2'h0
`define PLCC_ASPM_L0S      2'h1
`define PLCC_ASPM_L1       2'h2
`define PLCC_ASPM_BOTH     2'h3

// exit ordered-set counts under extended synch
`define PLCC_FTS_EXT       13'h1000
`define PLCC_TS1_EXT       11'h400
`define PLCC_FTS_W         13
`define PLCC_TS1_W         11
`define PLCC_UPSTREAM_PORT 2'h0

`endif

// [common/plcc_pkg.sv]
// types of the link capability / control bank
package plcc_pkg;
  `include "plcc_defs.svh"

  typedef logic [1:0]  plcc_port_t;
  typedef logic [7:0]  plcc_addr_t;
  typedef logic [31:0] plcc_word_t;

  // loadable capability defaults of one port
  typedef struct packed {
    logic [3:0] speed;
    logic [1:0] aspm;
    logic [2:0] l0sLat;
    logic [2:0] l1Lat;
    logic [7:0] portNum;
  } plcc_cap_t;

  // writable control bits of one port
  typedef struct packed {
    logic [1:0] aspm;
    logic       disable_;
    logic       commonClock;
    logic       extSynch;
    logic       hwWidthDis;
    logic       bwMgmtIe;
    logic       autoBwIe;
  } plcc_ctl_t;

  typedef enum logic [1:0] {
    PLCC_TR_IDLE,
    PLCC_TR_RUN
  } plcc_train_t;
endpackage

// [src/plcc_link_regs.sv]
// link capabilities and link control registers for all four switch ports
// Functional notes
// - aspm control 00 off, 01 l0s only, 10 l1 only, 11 both
// - receiver may always enter l0s, regardless of aspm control
// - link disable works downstream; upstream hardwired zero, writes ignored
// - retrain write starts training downstream; upstream hardwired zero
// - retrain bit always reads zero
// - common clock bit writable, resets zero
// - extended synch selects 4096 fts and 1024 ts1 exit sets
// - bandwidth interrupt enables writable downstream only, reset zero
// - read completion boundary reads zero
// - max link speed bits 3:0, reset 5 gb/s code
// - loadable capability defaults overridable by smbus or eeprom load
// - max link width bits 9:4, reset x1
// - aspm support read-only, resets zero; l0s and l1 still supported
// - l0s exit latency resets to code three
// - l1 exit latency resets to code zero
// - data link active reporting capable reads zero
// - bandwidth notify capable zero upstream, one downstream
// - port number resets to own port index
// - hardware autonomous width disable writable, resets zero
// - link training status held during retraining, cleared on completion
`timescale 1ns/1ps
`include "plcc_defs.svh"

module plcc_link_regs
  import plcc_pkg::*;
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  clockEnable,
  // configuration register port
  input  wire plcc_pkg::plcc_port_t  cfgPort,
  input  wire plcc_pkg::plcc_addr_t  cfgAddr,
  input  wire plcc_pkg::plcc_word_t  cfgWriteData,
  input  wire logic                  cfgWrite,
  input  wire logic                  cfgRead,
  output plcc_pkg::plcc_word_t       cfgReadData,
  // smbus / eeprom capability load
  input  wire plcc_pkg::plcc_port_t  loadPort,
  input  wire plcc_pkg::plcc_cap_t   loadCap,
  input  wire logic                  loadWrite,
  // link training state machine, one bit per port
  output logic [3:0]                 retrainReq,
  output logic [3:0]                 linkDisable,
  input  wire logic [3:0]            trainingDone,
  output logic [3:0]                 linkTraining,
  // power management controls per port
  output logic [3:0]                 l0sEntryEn,
  output logic [3:0]                 l1EntryEn,
  output logic [3:0]                 rxL0sAllowed,
  output logic [3:0]                 commonClock,
  output logic [3:0]                 hwWidthDis,
  output logic [3:0]                 bwMgmtIe,
  output logic [3:0]                 autoBwIe,
  output logic [51:0]                ftsExitCount,
  output logic [43:0]                ts1ExitCount
);
  import plcc_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    plcc_cap_t   [3:0] cap;
    plcc_ctl_t   [3:0] ctl;
    plcc_train_t [3:0] train;
    logic        [3:0] retrain;
    plcc_word_t        rdata;
  } plcc_state_t;

  plcc_state_t state;
  plcc_state_t next_state;

  // ==========================================================
  // strobe decode
  // decodes stay combinational; only the state struct is registered
  logic       ctlWriteHit;
  logic       cfgIsDown;
  logic [3:0] ctlWriteSel;
  logic [3:0] downWriteSel;
  logic [3:0] loadSel;
  logic [3:0] retrainSet;
  logic [3:0] trainEnd;

  assign ctlWriteHit = cfgWrite && (cfgAddr == `PLCC_OFF_LINK_CTL);
  assign cfgIsDown   = (cfgPort != `PLCC_UPSTREAM_PORT);

  // ==========================================================
  // reset image
  function automatic plcc_state_t resetImage();
    plcc_state_t s;
    s = '0;
    for (int p = 0; p < `PLCC_NUM_PORTS; p++) begin
      s.cap[p].speed   = `PLCC_RST_SPEED;
      s.cap[p].aspm    = `PLCC_RST_ASPM;
      s.cap[p].l0sLat  = `PLCC_RST_L0S;
      s.cap[p].l1Lat   = `PLCC_RST_L1;
      s.cap[p].portNum = 8'(p);
      s.train[p]       = PLCC_TR_IDLE;
    end
    return s;
  endfunction

  // ==========================================================
  // read images
  function automatic plcc_word_t capWord(plcc_cap_t c, plcc_port_t p);
    plcc_word_t w;
    w = '0;
    w[`PLCC_CAP_SPEED_HI:`PLCC_CAP_SPEED_LO] = c.speed;
    w[`PLCC_CAP_WIDTH_HI:`PLCC_CAP_WIDTH_LO] = `PLCC_RST_WIDTH;
    w[`PLCC_CAP_ASPM_HI:`PLCC_CAP_ASPM_LO]   = c.aspm;
    w[`PLCC_CAP_L0S_HI:`PLCC_CAP_L0S_LO]     = c.l0sLat;
    w[`PLCC_CAP_L1_HI:`PLCC_CAP_L1_LO]       = c.l1Lat;
    w[`PLCC_CAP_DLLA]                        = 1'b0;
    w[`PLCC_CAP_BWN] = (p != `PLCC_UPSTREAM_PORT);
    w[`PLCC_CAP_PNUM_HI:`PLCC_CAP_PNUM_LO]   = c.portNum;
    return w;
  endfunction

  function automatic plcc_word_t ctlWord(plcc_ctl_t c);
    plcc_word_t w;
    w = '0;
    w[`PLCC_CTL_ASPM_HI:`PLCC_CTL_ASPM_LO] = c.aspm;
    w[`PLCC_CTL_RCB]     = 1'b0;
    w[`PLCC_CTL_DISABLE] = c.disable_;
    w[`PLCC_CTL_RETRAIN] = 1'b0;
    w[`PLCC_CTL_CCLK]    = c.commonClock;
    w[`PLCC_CTL_EXTSYNC] = c.extSynch;
    w[`PLCC_CTL_HAWD]    = c.hwWidthDis;
    w[`PLCC_CTL_BWMIE]   = c.bwMgmtIe;
    w[`PLCC_CTL_ABWIE]   = c.autoBwIe;
    return w;
  endfunction

  // ==========================================================
  // control write
  // upstream keeps disable, retrain and the bandwidth enables at zero
  function automatic plcc_ctl_t ctlAfterWrite(plcc_ctl_t c, plcc_word_t v, logic down);
    plcc_ctl_t n;
    n             = c;
    n.aspm        = v[`PLCC_CTL_ASPM_HI:`PLCC_CTL_ASPM_LO];
    n.commonClock = v[`PLCC_CTL_CCLK];
    n.extSynch    = v[`PLCC_CTL_EXTSYNC];
    n.hwWidthDis  = v[`PLCC_CTL_HAWD];
    if (down) begin
      n.disable_  = v[`PLCC_CTL_DISABLE];
      n.bwMgmtIe  = v[`PLCC_CTL_BWMIE];
      n.autoBwIe  = v[`PLCC_CTL_ABWIE];
    end
    return n;
  endfunction

  // ==========================================================
  // training status of one port
  function automatic plcc_train_t trainStep(plcc_train_t t, logic start, logic done);
    plcc_train_t n;
    n = t;
    case (t)
      PLCC_TR_IDLE: begin
        if (start) begin
          n = PLCC_TR_RUN;
        end
      end
      PLCC_TR_RUN: begin
        if (done) begin
          n = PLCC_TR_IDLE;
        end
      end
      default: n = PLCC_TR_IDLE;
    endcase
    return n;
  endfunction

  // ==========================================================
  // read port
  // with clockEnable high nothing lingers on the read bus, so a stale word is never taken for an answer
  function automatic plcc_word_t readWord(plcc_state_t s, logic rd,
                                          plcc_addr_t a, plcc_port_t p);
    plcc_word_t w;
    w = '0;
    if (rd) begin
      case (a)
        `PLCC_OFF_LINK_CAP: w = capWord(s.cap[p], p);
        `PLCC_OFF_LINK_CTL: w = ctlWord(s.ctl[p]);
        default:            w = '0;
      endcase
    end
    return w;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    next_state         = state;
    next_state.retrain = retrainSet;
    for (int p = 0; p < `PLCC_NUM_PORTS; p++) begin
      // control writes; the capability word is read-only to software
      if (ctlWriteSel[p]) begin
        next_state.ctl[p] = ctlAfterWrite(state.ctl[p], cfgWriteData, downWriteSel[p]);
      end
      // smbus / eeprom override of the loadable defaults
      if (loadSel[p]) begin
        next_state.cap[p] = loadCap;
      end
      next_state.train[p] = trainStep(state.train[p], state.retrain[p], trainEnd[p]);
    end
    // with clockEnable high, read data stand only in the cycle after the strobe
    next_state.rdata = readWord(state, cfgRead, cfgAddr, cfgPort);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= resetImage();
    end else if (clockEnable) begin
      state <= next_state;
    end
  end

  // ==========================================================
  // outputs
  assign cfgReadData = state.rdata;

  genvar g;
  generate
    for (g = 0; g < `PLCC_NUM_PORTS; g++) begin : gPort
      assign ctlWriteSel[g]  = ctlWriteHit && (cfgPort == plcc_port_t'(g));
      assign downWriteSel[g] = ctlWriteSel[g] && cfgIsDown;
      assign loadSel[g]      = loadWrite && (loadPort == plcc_port_t'(g));
      assign retrainSet[g]   = downWriteSel[g] && cfgWriteData[`PLCC_CTL_RETRAIN];
      // a pending retrain outranks a done report, so a new request restarts the run
      assign trainEnd[g]     = trainingDone[g] && !state.retrain[g];
      assign retrainReq[g]   = state.retrain[g];
      assign linkDisable[g]  = state.ctl[g].disable_;
      assign linkTraining[g] = (state.train[g] == PLCC_TR_RUN);
      assign l0sEntryEn[g]   = state.ctl[g].aspm[0];
      assign l1EntryEn[g]    = state.ctl[g].aspm[1];
      assign rxL0sAllowed[g] = 1'b1;
      assign commonClock[g]  = state.ctl[g].commonClock;
      assign hwWidthDis[g]   = state.ctl[g].hwWidthDis;
      assign bwMgmtIe[g]     = state.ctl[g].bwMgmtIe;
      assign autoBwIe[g]     = state.ctl[g].autoBwIe;
      // zero means the ordinary counts chosen by the physical layer
      assign ftsExitCount[g*`PLCC_FTS_W +: `PLCC_FTS_W] =
        state.ctl[g].extSynch ? `PLCC_FTS_EXT : 13'h0000;
      assign ts1ExitCount[g*`PLCC_TS1_W +: `PLCC_TS1_W] =
        state.ctl[g].extSynch ? `PLCC_TS1_EXT : 11'h000;
    end
  endgenerate

endmodule // plcc_link_regs

// [dv/plcc_link_regs_props.sv]
// assertions on the ports of the link capability and control bank
`timescale 1ns/1ps
module plcc_link_regs_props
  import plcc_pkg::*;
(
  // clock, reset and register port
  input wire logic                 clock,
  input wire logic                 reset,
  input wire logic                 clockEnable,
  input wire plcc_pkg::plcc_port_t cfgPort,
  input wire plcc_pkg::plcc_addr_t cfgAddr,
  input wire plcc_pkg::plcc_word_t cfgWriteData,
  input wire logic                 cfgWrite,
  input wire logic                 cfgRead,
  input wire plcc_pkg::plcc_word_t cfgReadData,
  // per-port link controls
  input wire logic [3:0]           retrainReq,
  input wire logic [3:0]           linkDisable,
  input wire logic [3:0]           trainingDone,
  input wire logic [3:0]           linkTraining,
  input wire logic [3:0]           l0sEntryEn,
  input wire logic [3:0]           l1EntryEn
);
  logic [3:0] expReq;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // pulse rebuilt from the strobe, so a stuck or stored bit shows up
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      expReq <= 4'h0;
    end else begin
      expReq <= (cfgWrite && clockEnable && cfgAddr == 8'hd0 && cfgWriteData[5]
                 && cfgPort != 2'h0) ? 4'h1 << cfgPort : 4'h0;
    end
  end
  sequence s_retrainPort1;
    cfgWrite && clockEnable && cfgAddr == 8'hd0 && cfgWriteData[5] && cfgPort == 2'h1;
  endsequence
  sequence s_trainingRuns;
    retrainReq[1] ##1 linkTraining[1];
  endsequence
  chk_aspm_decode: assert property (cfgWrite && clockEnable && cfgAddr == 8'hd0 |=>
    {l1EntryEn[$past(cfgPort)], l0sEntryEn[$past(cfgPort)]} == $past(cfgWriteData[1:0]))
    else $error("aspm enables wrong");
  chk_upstream_hard: assert property (!linkDisable[0] && !retrainReq[0])
    else $error("upstream control active");
  chk_retrain_pulse: assert property ($past(clockEnable) |-> retrainReq == expReq)
    else $error("retrain pulse wrong");
  chk_train_start: assert property (s_retrainPort1 |=> s_trainingRuns)
    else $error("training did not start");
  chk_train_end: assert property (linkTraining[1] && trainingDone[1] && !retrainReq[1]
    && clockEnable |=> !linkTraining[1]) else $error("training not cleared");
  chk_read_idle: assert property (!$past(cfgRead) && $past(clockEnable) |-> cfgReadData == 0)
    else $error("read data outside slot");
  chk_ctl_reserved: assert property (cfgRead && clockEnable && cfgAddr == 8'hd0 |=>
    (cfgReadData & 32'hffff_f12c) == 32'h0) else $error("control reserved bits set");
  chk_cap_fixed: assert property (cfgRead && clockEnable && cfgAddr == 8'hcc |=>
    cfgReadData[23:18] == {2'h0, $past(cfgPort) != 2'h0, 3'h0} && cfgReadData[9:4] == 6'h01)
    else $error("fixed capability bits wrong");
endmodule // plcc_link_regs_props

bind plcc_link_regs plcc_link_regs_props i_plcc_link_regs_props (.*);

// [dv/plcc_ltssm_model.sv]
// link training partner: each retrain request gets a done pulse trainLen cycles later
`timescale 1ns/1ps
module plcc_ltssm_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // training handshake, one bit per port, and the training length shared by all ports
  input  wire logic [3:0] retrainReq,
  input  wire logic [7:0] trainLen,
  output logic      [3:0] trainingDone
);
  logic [7:0] remain [4];
  // a new request restarts the count, as a real partner retrains from scratch
  always_ff @(posedge clock or posedge reset) begin
    for (int p = 0; p < 4; p++) begin
      if (reset) begin
        remain[p] <= 8'h0;
      end else if (retrainReq[p]) begin
        remain[p] <= trainLen;
      end else if (remain[p] != 8'h0) begin
        remain[p] <= remain[p] - 8'h1;
      end
    end
  end
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      trainingDone[p] = remain[p] == 8'h1;
    end
  end
endmodule // plcc_ltssm_model

// [dv/tb_top.sv]
// random and directed bench for the link capability and control bank
`timescale 1ns/1ps
module tb_top;
  import plcc_pkg::*;
  logic        clock = 1'b0, reset = 1'b1, clockEnable = 1'b1;
  logic        cfgWrite = 1'b0, cfgRead = 1'b0, loadWrite = 1'b0;
  plcc_port_t  cfgPort = 2'h0, loadPort = 2'h0, p;
  plcc_addr_t  cfgAddr = 8'h0;
  plcc_word_t  cfgWriteData = 32'h0, cfgReadData, got, d, e;
  plcc_cap_t   loadCap = 20'h0, lc;
  logic [7:0]  trainLen = 8'h02;
  logic [3:0]  retrainReq, linkDisable, trainingDone, linkTraining, l0sEntryEn, l1EntryEn;
  logic [3:0]  rxL0sAllowed, commonClock, hwWidthDis, bwMgmtIe, autoBwIe;
  logic [51:0] ftsExitCount;
  logic [43:0] ts1ExitCount;
  int          n_errors = 0, check_count = 0, seed = 57446, k, n;
  always #2 clock = ~clock;
  plcc_link_regs i_plcc_link_regs (.*);
  plcc_ltssm_model i_plcc_ltssm_model (.*);
  // ==========
  // tasks and expectations
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one strobe cycle; read data taken in the single cycle it stands
  task automatic acc(logic w, plcc_port_t ap, plcc_addr_t a, plcc_word_t v);
    @(posedge clock);
    cfgWrite <= w;
    cfgRead <= !w;
    cfgPort <= ap;
    cfgAddr <= a;
    cfgWriteData <= v;
    @(posedge clock);
    cfgWrite <= 1'b0;
    cfgRead <= 1'b0;
    #1 got = cfgReadData;
  endtask
  task automatic waitTrain(logic lvl);
    for (n = 0; linkTraining[1] !== lvl; n++) begin
      if (n == 200) begin
        n_errors++;
        end_of_test();
      end
      @(posedge clock);
      #1;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  function automatic plcc_cap_t rstCap(int i);
    return {4'h2, 2'h0, 3'h3, 3'h0, 8'(i)};
  endfunction
  function automatic plcc_word_t capExp(int i, plcc_cap_t c);
    return {c.portNum, 2'h0, i != 0, 3'h0, c.l1Lat, c.l0sLat, c.aspm, 6'h01, c.speed};
  endfunction
  // ==========
  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    for (k = 0; k < 4; k++) begin
      acc(1'b0, 2'(k), 8'hcc, 32'h0);
      cmp("cap reset", capExp(k, rstCap(k)), got);
      acc(1'b0, 2'(k), 8'hd0, 32'h0);
      cmp("ctl reset", 32'h0, got);
    end
    // every aspm code on every port, other bits random
    for (k = 0; k < 16; k++) begin
      p = 2'(k);
      d = $random(seed);
      d[1:0] = 2'(k >> 2);
      e = d & (p == 2'h0 ? 32'h2c3 : 32'hed3);
      acc(1'b1, p, 8'hd0, d);
      cmp("aspm enables", d[1:0], {l1EntryEn[p], l0sEntryEn[p]});
      cmp("link disable", e[4], linkDisable[p]);
      cmp("ctl levels", {e[11:9], e[6]}, {autoBwIe[p], bwMgmtIe[p], hwWidthDis[p], commonClock[p]});
      cmp("exit sets", d[7] ? {13'h1000, 11'h400} : 24'h0, {ftsExitCount[13*p+:13], ts1ExitCount[11*p+:11]});
      cmp("rx l0s", 4'hf, rxL0sAllowed);
      acc(1'b0, p, 8'hd0, 32'h0);
      cmp("ctl readback", e, got);
    end
    // a write while frozen is not taken
    clockEnable <= 1'b0;
    acc(1'b1, 2'h3, 8'hd0, 32'hffff_ffff);
    clockEnable <= 1'b1;
    acc(1'b0, 2'h3, 8'hd0, 32'h0);
    cmp("frozen write", e, got);
    acc(1'b1, 2'h1, 8'hcc, 32'hffff_ffff);
    acc(1'b0, 2'h1, 8'hcc, 32'h0);
    cmp("cap write", capExp(1, rstCap(1)), got);
    acc(1'b0, 2'h2, 8'h40, 32'h0);
    cmp("unmapped", 32'h0, got);
    for (k = 0; k < 4; k++) begin
      lc = 20'($random(seed));
      @(posedge clock);
      loadPort <= 2'(k);
      loadCap <= lc;
      loadWrite <= 1'b1;
      @(posedge clock);
      loadWrite <= 1'b0;
      acc(1'b0, 2'(k), 8'hcc, 32'h0);
      cmp("cap load", capExp(k, lc), got);
    end
    // prompt and then slow partner
    for (k = 0; k < 2; k++) begin
      trainLen <= k ? 8'h28 : 8'h02;
      waitTrain(1'b0);
      acc(1'b1, 2'h1, 8'hd0, 32'h20);
      cmp("retrain pulse", 4'h2, retrainReq);
      waitTrain(1'b1);
      acc(1'b0, 2'h1, 8'hd0, 32'h0);
      cmp("retrain readback", 32'h0, got);
      cmp("still training", k, linkTraining[1]);
      waitTrain(1'b0);
    end
    // reset with training idle restores the defaults, loaded values included
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    for (k = 0; k < 4; k++) begin
      acc(1'b0, 2'(k), 8'hcc, 32'h0);
      cmp("cap after reset", capExp(k, rstCap(k)), got);
      acc(1'b0, 2'(k), 8'hd0, 32'h0);
      cmp("ctl after reset", 32'h0, got);
    end
    end_of_test();
  end
endmodule // tb_top
